// *** hdl/port_transfer.sv ***
`timescale 1ns/1ns
`default_nettype none
module port_transfer (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // received words from the decoder
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [17:0] rx_data,
  // port set-up, sampled on xfer_start except loop_source_enable and test_port_hit, which gate loop_source_active live
  input  wire logic        xfer_start,
  input  wire logic [15:0] port_a_base,
  input  wire logic [15:0] port_b_base,
  input  wire logic [15:0] pcs_base,
  input  wire logic [15:0] force_base,
  input  wire logic        valid_page,
  input  wire logic [2:0]  transfer_irq_select,
  input  wire logic        port_a_sink,
  input  wire logic        port_a_source,
  input  wire logic        port_b_used,
  input  wire logic        port_b_sink,
  input  wire logic        port_b_source,
  input  wire logic        force_enable,
  input  wire logic        user_check_sequence_enable,
  input  wire logic        keep_erroneous_data,
  input  wire logic        queued,
  input  wire logic        test_port_hit,
  input  wire logic        loop_source_enable,
  input  wire logic        loop_sink_enable,
  // traffic memory
  output logic             tm_req,
  output logic             tm_we,
  output logic [15:0]      tm_addr,
  output logic [15:0]      tm_wdata,
  input  wire logic        tm_ack,
  input  wire logic [15:0] tm_rdata,
  // status
  output logic             busy,
  output logic             transfer_interrupt,
  output logic [2:0]       irq_code,
  output logic             crc_error,
  output logic             source_conflict,
  output logic             loop_source_active,
  output logic             cs_from_memory,
  // master frames and synchro strobe
  input  wire logic        mf_valid,
  input  wire logic [11:0] mf_addr,
  input  wire logic        mf_multi_port,
  input  wire logic        single_class_mode,
  input  wire logic [2:0]  memory_config_mode,
  output logic             strobe_n,
  output logic [11:0]      sync_port_index
);
  xfer_pkg::xfer_state_e state, next_state;
  logic [15:0] base_a, next_base_a, base_b, next_base_b;
  logic [15:0] port_control_status, next_pcs, fbase, next_fbase;
  logic [15:0] word, next_word, mask, next_mask, tmp, next_tmp;
  logic [7:0]  cs, next_cs;
  logic [3:0]  idx, next_idx;
  logic [2:0]  sel, next_sel;
  logic        vp, next_vp, dual, next_dual, fen, next_fen, ucs, next_ucs;
  logic        keep, next_keep, que, next_que, cmp, next_cmp;
  logic        diff, next_diff, crc, next_crc, irq, next_irq;
  logic        conflict, next_conflict, ready_c, wpage;
  logic [1:0]  scount, next_scount;
  logic        next_strobe_n;
  logic [11:0] next_sync_idx;

  stream_if #(.WIDTH(xfer_pkg::WORD_W)) in_s ();
  stream_if #(.WIDTH(xfer_pkg::WORD_W)) out_s ();

  // four words of slack so the decoder can run ahead of memory stalls
  assign in_s.valid = rx_valid;
  assign in_s.data  = rx_data;
  assign rx_ready   = in_s.ready;
  assign out_s.ready = ready_c;

  word_fifo #(.WIDTH(xfer_pkg::WORD_W), .DEPTH(xfer_pkg::FIFO_DEPTH)) u_fifo (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .wr   (in_s),
    .rd   (out_s)
  );

  function automatic logic [15:0] data_addr(input logic [15:0] b, input logic pg,
                                            input logic [3:0] i);
    data_addr = b + (pg ? xfer_pkg::PAGE_OFS : 16'h0000) + {12'h000, i};
  endfunction

  // queued data has one block only, so both pages are the same
  assign wpage = que ? vp : !vp;
  assign busy  = (state != xfer_pkg::ST_IDLE);
  assign ready_c = (state == xfer_pkg::ST_POP);
  assign cs_from_memory = ucs && busy;
  assign loop_source_active = test_port_hit && loop_source_enable;
  assign transfer_interrupt = irq;
  assign source_conflict = conflict;
  assign crc_error = crc;

  always_comb
  begin
    tm_req   = 1'b1;
    tm_we    = 1'b0;
    tm_addr  = 16'h0000;
    tm_wdata = 16'h0000;
    case (state)
      xfer_pkg::ST_RD_MASK:  tm_addr = fbase + {12'h000, idx};
      xfer_pkg::ST_RD_FDATA: tm_addr = fbase + xfer_pkg::PAGE_OFS + {12'h000, idx};
      xfer_pkg::ST_RD_OLD:   tm_addr = data_addr(base_a, vp, idx);
      xfer_pkg::ST_WR_A:
      begin
        tm_we    = 1'b1;
        tm_addr  = data_addr(base_a, wpage, idx);
        tm_wdata = word;
      end
      xfer_pkg::ST_WR_B:
      begin
        tm_we    = 1'b1;
        tm_addr  = data_addr(base_b, wpage, idx);
        tm_wdata = word;
      end
      xfer_pkg::ST_RD_CS:    tm_addr = port_control_status + xfer_pkg::PCS3_OFS;
      xfer_pkg::ST_WR_CS:
      begin
        tm_we    = 1'b1;
        tm_addr  = port_control_status + xfer_pkg::PCS3_OFS;
        // 16-bit memory only, so the other page's octet is kept
        tm_wdata = wpage ? {cs, tmp[7:0]} : {tmp[15:8], cs};
      end
      xfer_pkg::ST_RD_PCS1:  tm_addr = port_control_status + xfer_pkg::PCS1_OFS;
      xfer_pkg::ST_WR_PCS1:
      begin
        tm_we    = 1'b1;
        tm_addr  = port_control_status + xfer_pkg::PCS1_OFS;
        tm_wdata = que ? tmp : (tmp ^ xfer_pkg::VP_MASK);
      end
      default:               tm_req = 1'b0;
    endcase
  end

  always_comb
  begin
    next_state = state;
    next_base_a = base_a;
    next_base_b = base_b;
    next_pcs = port_control_status;
    next_fbase = fbase;
    next_word = word;
    next_mask = mask;
    next_tmp = tmp;
    next_cs = cs;
    next_idx = idx;
    next_sel = sel;
    next_vp = vp;
    next_dual = dual;
    next_fen = fen;
    next_ucs = ucs;
    next_keep = keep;
    next_que = que;
    next_cmp = cmp;
    next_diff = diff;
    next_crc = crc;
    next_irq = 1'b0;
    next_conflict = 1'b0;
    case (state)
      xfer_pkg::ST_IDLE:
        if (xfer_start)
        begin
          next_conflict = port_b_used && port_a_source && port_b_source;
          next_base_a = (test_port_hit || !port_a_sink) ?
                        (test_port_hit ? xfer_pkg::MSG_BASE : port_b_base) : port_a_base;
          next_base_b = port_b_base;
          next_dual = port_b_used && port_a_sink && port_b_sink;
          next_pcs = pcs_base;
          next_fbase = force_base;
          next_vp = valid_page;
          next_sel = transfer_irq_select;
          next_fen = force_enable;
          next_ucs = user_check_sequence_enable;
          next_keep = keep_erroneous_data;
          next_que = queued;
          next_cmp = (transfer_irq_select == xfer_pkg::IRQ_COMPARE);
          next_diff = 1'b0;
          next_crc = 1'b0;
          next_idx = 4'h0;
          if ((port_a_sink || (port_b_used && port_b_sink)) &&
              !(test_port_hit && !loop_sink_enable))
            next_state = xfer_pkg::ST_POP;
        end
      xfer_pkg::ST_POP:
        if (out_s.valid)
          case (out_s.data[17:16])
            xfer_pkg::KIND_DATA:
            begin
              next_word = out_s.data[15:0];
              if (fen)
                next_state = xfer_pkg::ST_RD_MASK;
              else if (cmp && !diff)
                next_state = xfer_pkg::ST_RD_OLD;
              else
                next_state = xfer_pkg::ST_WR_A;
            end
            xfer_pkg::KIND_CS:
            begin
              // octets bypass the comparison path entirely
              next_cs = out_s.data[7:0];
              next_crc = crc || (out_s.data[15:8] != out_s.data[7:0]);
              next_state = ucs ? xfer_pkg::ST_RD_CS : xfer_pkg::ST_POP;
            end
            default:
              // errored frame lands in the hidden page and is published only with keep set and length unaltered
              if (!out_s.data[xfer_pkg::END_BAD_BIT] ||
                  (keep && !out_s.data[xfer_pkg::END_ALTER_BIT]))
                next_state = xfer_pkg::ST_RD_PCS1;
              else
                next_state = xfer_pkg::ST_IDLE;
          endcase
      xfer_pkg::ST_RD_MASK:
        if (tm_ack)
        begin
          next_mask = tm_rdata;
          next_state = xfer_pkg::ST_RD_FDATA;
        end
      xfer_pkg::ST_RD_FDATA:
        if (tm_ack)
        begin
          next_word = (word & ~mask) | (tm_rdata & mask);
          next_state = (cmp && !diff) ? xfer_pkg::ST_RD_OLD : xfer_pkg::ST_WR_A;
        end
      xfer_pkg::ST_RD_OLD:
        if (tm_ack)
        begin
          next_diff = diff || (tm_rdata != word);
          next_state = xfer_pkg::ST_WR_A;
        end
      xfer_pkg::ST_WR_A:
        if (tm_ack)
        begin
          next_state = dual ? xfer_pkg::ST_WR_B : xfer_pkg::ST_POP;
          if (!dual)
            next_idx = idx + 4'h1;
        end
      xfer_pkg::ST_WR_B:
        if (tm_ack)
        begin
          next_idx = idx + 4'h1;
          next_state = xfer_pkg::ST_POP;
        end
      xfer_pkg::ST_RD_CS:
        if (tm_ack)
        begin
          next_tmp = tm_rdata;
          next_state = xfer_pkg::ST_WR_CS;
        end
      xfer_pkg::ST_WR_CS:
        if (tm_ack)
          next_state = xfer_pkg::ST_POP;
      xfer_pkg::ST_RD_PCS1:
        if (tm_ack)
        begin
          next_tmp = tm_rdata;
          next_state = xfer_pkg::ST_WR_PCS1;
        end
      xfer_pkg::ST_WR_PCS1:
        if (tm_ack)
          next_state = xfer_pkg::ST_IRQ;
      xfer_pkg::ST_IRQ:
      begin
        next_irq = (sel != xfer_pkg::IRQ_NONE) && (!cmp || diff);
        next_state = xfer_pkg::ST_IDLE;
      end
      default:
        next_state = xfer_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= xfer_pkg::ST_IDLE;
      base_a <= 16'h0000;
      base_b <= 16'h0000;
      port_control_status <= 16'h0000;
      fbase <= 16'h0000;
      word <= 16'h0000;
      mask <= 16'h0000;
      tmp <= 16'h0000;
      cs <= 8'h00;
      idx <= 4'h0;
      sel <= 3'h0;
      irq_code <= 3'h0;
      {vp, dual, fen, ucs, keep, que, cmp, diff, crc, irq, conflict} <= 11'h000;
    end
    else if (ce)
    begin
      state <= next_state;
      base_a <= next_base_a;
      base_b <= next_base_b;
      port_control_status <= next_pcs;
      fbase <= next_fbase;
      word <= next_word;
      mask <= next_mask;
      tmp <= next_tmp;
      cs <= next_cs;
      idx <= next_idx;
      sel <= next_sel;
      irq_code <= next_irq ? sel : irq_code;
      {vp, dual, fen, ucs, keep, que, cmp, diff, crc, irq, conflict} <=
        {next_vp, next_dual, next_fen, next_ucs, next_keep, next_que, next_cmp,
         next_diff, next_crc, next_irq, next_conflict};
    end
  end

  // synchro strobe: address match on a single-port frame decides, port set-up is ignored
  always_comb
  begin
    next_scount = (scount != 2'h0) ? scount - 2'h1 : 2'h0;
    if (mf_valid && (mf_addr == xfer_pkg::SYNC_ADDR) && !mf_multi_port)
      next_scount = xfer_pkg::STROBE_CYCLES;
    next_strobe_n = (next_scount == 2'h0);
    if (single_class_mode)
      next_sync_idx = xfer_pkg::SYNC_IDX_CLASS1;
    else if (memory_config_mode < xfer_pkg::MCM_MID)
      next_sync_idx = xfer_pkg::SYNC_IDX_SMALL;
    else if (memory_config_mode == xfer_pkg::MCM_MID)
      next_sync_idx = xfer_pkg::SYNC_IDX_MID;
    else
      next_sync_idx = xfer_pkg::SYNC_IDX_LARGE;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      scount <= 2'h0;
      strobe_n <= 1'b1;
      sync_port_index <= 12'h000;
    end
    else if (ce)
    begin
      scount <= next_scount;
      strobe_n <= next_strobe_n;
      sync_port_index <= next_sync_idx;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  logic [2:0] low_run;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      low_run <= 3'h0;
    else if (ce)
      low_run <= strobe_n ? 3'h0 : low_run + 3'h1;
  end

  a_strobe_fires: assert property (ce && mf_valid && mf_addr == 12'hFFF && !mf_multi_port
    ##1 ce |-> !strobe_n) else $error("strobe missed sync frame");
  a_strobe_hold: assert property ($fell(strobe_n) |-> !strobe_n [*3])
    else $error("strobe shorter than three cycles");
  a_strobe_max: assert property (low_run <= 3'h3)
    else $error("strobe longer than three cycles");
  a_multi_quiet: assert property (ce && strobe_n && mf_valid && mf_multi_port
    |=> strobe_n) else $error("strobe on multi-port frame");
  a_skip_read: assert property (ce && diff |-> state != xfer_pkg::ST_RD_OLD)
    else $error("old word read after difference");
  a_irq_order: assert property (irq |-> $past(state, 2) == xfer_pkg::ST_WR_PCS1
    || $past(state, 2) == xfer_pkg::ST_IRQ) else $error("interrupt before control word");
  a_cmp_gate: assert property (irq && cmp |-> diff)
    else $error("compare interrupt without change");
  a_write_page: assert property (state == xfer_pkg::ST_WR_A && !que
    |-> tm_addr == data_addr(base_a, !vp, idx)) else $error("wrong page written");
  a_sync_index: assert property (ce && single_class_mode |=> sync_port_index == 12'h00F)
    else $error("class one synchro index");
  a_cs_rmw: assert property (ce && state == xfer_pkg::ST_WR_CS && tm_ack
    |-> $past(state, 1) inside {xfer_pkg::ST_WR_CS, xfer_pkg::ST_RD_CS})
    else $error("check octet written without read");

  c_compare_hit: cover property (irq && cmp);
  c_strobe: cover property ($fell(strobe_n));
  c_dual_sink: cover property (state == xfer_pkg::ST_WR_B && tm_ack);
  c_cs_write: cover property (state == xfer_pkg::ST_WR_CS && tm_ack);
endmodule
`default_nettype wire

// *** hdl/xfer_pkg.sv ***
// Contract
// - compare mode when interrupt select is all ones on an active sink port
// - in compare mode interrupt only if some received word differs from stored one
// - read old word from current page, compare, write to other page; skip reads after difference
// - queued data compares against and overwrites the same block
// - check sequence octets never take part in comparison
// - with forcing, read mask and force data, force first, then compare
// - logical address 0x0FFF is the synchro port, any function code, every mode
// - strobe fires on any single-port master frame whose low 12 address bits are all ones
// - each synchro transfer drives strobe active for exactly three clocks
// - synchro port index is 255, 1023 or 4095 by mode; 15 in single class
// - no strobe when one frame covers several ports ending at port 15
// - user check sequence sent from memory; decoder mismatch flagged as crc error
// - both page check octets live in control word 3, updated by read-modify-write
// - check sequence accessed after every 4 words, or once for short frames
// - extra accesses are max(1,n/4) times 1 for send, 2 for receive
// - with keep flag, erroneous frames of unaltered length are stored
// - with keep flag and user check sequence, received octet stored even if wrong
// - only one source per telegram; two sinks both receive the data
// - test ports share message port memory, each enabled by its own bit
// - interrupt only after data, acknowledges and control word 1 update finish
package xfer_pkg;
  localparam int          DATA_W        = 16;
  localparam int          WORD_W        = 18;
  localparam int          FIFO_DEPTH    = 4;
  localparam logic [1:0]  KIND_DATA     = 2'h0;
  localparam logic [1:0]  KIND_CS       = 2'h1;
  localparam logic [1:0]  KIND_END      = 2'h2;
  localparam int          END_BAD_BIT   = 0;
  localparam int          END_ALTER_BIT = 1;
  localparam logic [2:0]  IRQ_COMPARE   = 3'h7;
  localparam logic [2:0]  IRQ_NONE      = 3'h0;
  localparam logic [11:0] SYNC_ADDR     = 12'hFFF;
  localparam int          CLK_NS        = 100;
  localparam logic [1:0]  STROBE_CYCLES = 2'h3;
  localparam logic [15:0] PCS1_OFS      = 16'h0001;
  localparam logic [15:0] PCS3_OFS      = 16'h0003;
  localparam logic [15:0] PAGE_OFS      = 16'h0010;
  localparam logic [15:0] MSG_BASE      = 16'h0100;
  localparam logic [15:0] VP_MASK       = 16'h0001;
  localparam logic [11:0] SYNC_IDX_SMALL = 12'h0FF;
  localparam logic [11:0] SYNC_IDX_MID   = 12'h3FF;
  localparam logic [11:0] SYNC_IDX_LARGE = 12'hFFF;
  localparam logic [11:0] SYNC_IDX_CLASS1 = 12'h00F;
  localparam logic [2:0]  MCM_MID       = 3'h2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_POP, ST_RD_MASK, ST_RD_FDATA, ST_RD_OLD, ST_WR_A, ST_WR_B,
    ST_RD_CS, ST_WR_CS, ST_RD_PCS1, ST_WR_PCS1, ST_IRQ
  } xfer_state_e;
endpackage

// *** hdl/stream_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(parameter int WIDTH = 18);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** hdl/word_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  // clock
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  // streams
  stream_if.snk     wr,
  stream_if.src     rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW:0]      wp;
  logic [AW:0]      rp;
  logic [AW:0]      next_wp;
  logic [AW:0]      next_rp;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full     = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty    = (wp == rp);
  assign wr.ready = ce && !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp[AW-1:0]];
  assign push     = wr.valid && wr.ready;
  assign pop      = ce && rd.valid && rd.ready;

  always_comb
  begin
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      always_comb
      begin
        next_mem[i] = (push && (wp[AW-1:0] == AW'(i))) ? wr.data : mem[i];
      end
      always_ff @(posedge mclk or negedge nrst)
      begin
        if (!nrst)
          mem[i] <= '0;
        else if (ce)
          mem[i] <= next_mem[i];
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp <= '0;
      rp <= '0;
    end
    else if (ce)
    begin
      wp <= next_wp;
      rp <= next_rp;
    end
  end
endmodule
`default_nettype wire

// *** tb/tm_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module tm_model (
  // clock
  input  wire logic        mclk,
  input  wire logic        nrst,
  // memory access
  input  wire logic        tm_req,
  input  wire logic        tm_we,
  input  wire logic [15:0] tm_addr,
  input  wire logic [15:0] tm_wdata,
  output logic             tm_ack,
  output logic [15:0]      tm_rdata,
  // pacing
  input  wire logic        slow
);
  logic [15:0] mem [0:2047];
  logic [1:0]  wait_cnt;
  // rdata inverted off the ack cycle so a late sample never looks right
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tm_ack   <= 1'b0;
      wait_cnt <= 2'h0;
      tm_rdata <= 16'h0000;
    end
    else if (tm_ack)
    begin
      tm_ack   <= 1'b0;
      tm_rdata <= ~tm_rdata;
      if (tm_we)
        mem[tm_addr[10:0]] <= tm_wdata;
    end
    else if (tm_req && wait_cnt == (slow ? 2'h3 : 2'h0))
    begin
      tm_ack   <= 1'b1;
      wait_cnt <= 2'h0;
      tm_rdata <= tm_we ? ~tm_rdata : mem[tm_addr[10:0]];
    end
    else if (tm_req)
      wait_cnt <= wait_cnt + 2'h1;
  end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        rx_valid = 1'b0;
  logic        xfer_start = 1'b0;
  logic        valid_page = 1'b0;
  logic        mf_valid = 1'b0;
  logic        mf_multi_port = 1'b0;
  logic        single_class_mode = 1'b0;
  logic        slow = 1'b0;
  logic [17:0] rx_data = 18'h00000;
  logic [2:0]  sel = 3'h0;
  logic [2:0]  memory_config_mode = 3'h0;
  logic [4:0]  role = 5'h00;
  logic [6:0]  fl = 7'h00;
  logic [11:0] mf_addr = 12'h000;
  logic [15:0] dw [8];
  logic        rx_ready, tm_req, tm_we, tm_ack, busy, transfer_interrupt, crc_error;
  logic        source_conflict, loop_source_active, cs_from_memory, strobe_n;
  logic        irq_seen, conf_seen, csm_seen, full_seen;
  logic [2:0]  irq_code, irq_cap;
  logic [11:0] sync_port_index;
  logic [15:0] tm_addr, tm_wdata, tm_rdata;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n_acc = 0;
  int          cycles = 0;

  port_transfer dut (
    .mclk, .nrst, .ce, .rx_valid, .rx_ready, .rx_data, .xfer_start,
    .port_a_base(16'h0200), .port_b_base(16'h0400), .pcs_base(16'h0300),
    .force_base(16'h0500), .valid_page, .transfer_irq_select(sel),
    .port_a_sink(role[0]), .port_a_source(role[1]), .port_b_used(role[2]),
    .port_b_sink(role[3]), .port_b_source(role[4]), .force_enable(fl[0]),
    .user_check_sequence_enable(fl[1]), .keep_erroneous_data(fl[2]), .queued(fl[3]),
    .test_port_hit(fl[4]), .loop_source_enable(fl[5]), .loop_sink_enable(fl[6]),
    .tm_req, .tm_we, .tm_addr, .tm_wdata, .tm_ack, .tm_rdata, .busy, .transfer_interrupt,
    .irq_code, .crc_error, .source_conflict, .loop_source_active, .cs_from_memory,
    .mf_valid, .mf_addr, .mf_multi_port, .single_class_mode, .memory_config_mode,
    .strobe_n, .sync_port_index
  );
  tm_model tm (.mclk, .nrst, .tm_req, .tm_we, .tm_addr, .tm_wdata, .tm_ack, .tm_rdata, .slow);

  initial forever #50 mclk = ~mclk;

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] want, input logic [15:0] got);
    n_checks++;
    if (got !== want)
    begin
      $display("[ERR] %s expected %h seen %h", what, want, got);
      n_errors++;
    end
  endtask

  // sampled values are pre-edge, so pulses are caught in their own cycle
  always @(posedge mclk)
  begin
    cycles++;
    if (tm_req === 1'b1 && tm_ack === 1'b1)
      n_acc++;
    if (transfer_interrupt === 1'b1)
    begin
      irq_seen = 1'b1;
      irq_cap = irq_code;
    end
    if (source_conflict === 1'b1)
      conf_seen = 1'b1;
    if (cs_from_memory === 1'b1)
      csm_seen = 1'b1;
    if (rx_valid === 1'b1 && rx_ready === 1'b0)
      full_seen = 1'b1;
    if (cycles == 30000)
    begin
      n_errors++;
      close_out;
    end
  end

  // check entry after every 4 words and after the last word of the frame
  task automatic frame(input int n, input logic cs, input logic [15:0] csw, input logic [1:0] e);
    logic [17:0] q[$];
    int i;
    for (i = 0; i < n; i++)
    begin
      q.push_back({2'h0, dw[i]});
      if (cs && (i % 4 == 3 || i == n - 1))
        q.push_back({2'h1, csw});
    end
    q.push_back({2'h2, 14'h0000, e});
    {irq_seen, conf_seen, csm_seen, full_seen} = 4'h0;
    n_acc = 0;
    xfer_start <= 1'b1;
    @(posedge mclk);
    xfer_start <= 1'b0;
    foreach (q[k])
    begin
      rx_valid <= 1'b1;
      rx_data <= q[k];
      @(negedge mclk);
      while (rx_ready !== 1'b1)
        @(negedge mclk);
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    for (i = 0; busy !== 1'b0 && i < 300; i++)
      @(negedge mclk);
    chk("idle", 16'h0000, 16'(busy));
    repeat (4) @(posedge mclk);
  endtask

  task automatic pulse(input logic [11:0] a, input logic m, output logic [3:0] s);
    mf_addr <= a;
    mf_multi_port <= m;
    mf_valid <= 1'b1;
    @(posedge mclk);
    mf_valid <= 1'b0;
    repeat (4)
    begin
      @(negedge mclk);
      s = {strobe_n, s[3:1]};
    end
    @(posedge mclk);
  endtask

  task automatic t_strobe;
    logic [3:0] s;
    chk("rst strobe", 16'h0001, 16'(strobe_n));
    pulse(12'hFFF, 1'b1, s);
    chk("multi", 16'h000F, 16'(s));
    pulse(12'h7FF, 1'b0, s);
    chk("other", 16'h000F, 16'(s));
    ce <= 1'b0;
    pulse(12'hFFF, 1'b0, s);
    ce <= 1'b1;
    chk("frozen", 16'h000F, 16'(s));
    $display("strobe done");
  endtask

  task automatic t_index;
    logic [11:0] want [6];
    logic [3:0]  s;
    want = '{12'h0FF, 12'h0FF, 12'h3FF, 12'hFFF, 12'hFFF, 12'h00F};
    for (int m = 0; m < 6; m++)
    begin
      single_class_mode <= (m == 5);
      memory_config_mode <= (m == 5) ? 3'h0 : 3'(m);
      pulse(12'hFFF, 1'b0, s);
      chk("sync idx", 16'(want[m]), 16'(sync_port_index));
      chk("sync strobe", 16'h0008, 16'(s));
    end
    $display("index done");
  endtask

  task automatic t_compare;
    for (int i = 0; i < 4; i++)
    begin
      dw[i] = 16'h1100 + 16'(i);
      tm.mem[16'h0200 + i] = dw[i];
    end
    role <= 5'h01;
    sel <= 3'h7;
    frame(4, 1'b0, 16'h0000, 2'h0);
    chk("same acc", 16'h000A, 16'(n_acc));
    chk("same irq", 16'h0000, 16'(irq_seen));
    chk("new page", dw[3], tm.mem[16'h0213]);
    chk("pcs1 flip", 16'h0001, tm.mem[16'h0301]);
    dw[1] = 16'hBEEF;
    slow <= 1'b1;
    frame(4, 1'b0, 16'h0000, 2'h0);
    chk("diff acc", 16'h0008, 16'(n_acc));
    chk("diff irq", 16'h0001, 16'(irq_seen));
    chk("irq code", 16'h0007, 16'(irq_cap));
    fl <= 7'h08;
    frame(4, 1'b0, 16'h0000, 2'h0);
    chk("queue irq", 16'h0001, 16'(irq_seen));
    chk("queue wr", 16'hBEEF, tm.mem[16'h0201]);
    chk("queue vp", 16'h0000, tm.mem[16'h0301]);
    $display("compare done");
  endtask

  // slow memory left on so the four-word buffer fills and refuses
  task automatic t_check_seq;
    for (int i = 0; i < 8; i++)
      dw[i] = 16'h3000 + 16'(i);
    tm.mem[16'h0303] = 16'h1234;
    sel <= 3'h1;
    fl <= 7'h02;
    frame(8, 1'b1, 16'h5A5A, 2'h0);
    chk("cs acc", 16'h000E, 16'(n_acc));
    chk("cs word", 16'h5A34, tm.mem[16'h0303]);
    chk("crc ok", 16'h0000, 16'(crc_error));
    chk("cs src", 16'h0001, 16'(csm_seen));
    chk("fifo full", 16'h0001, 16'(full_seen));
    fl <= 7'h06;
    frame(4, 1'b1, 16'hA53C, 2'h1);
    chk("crc bad", 16'h0001, 16'(crc_error));
    chk("cs kept", 16'h3C34, tm.mem[16'h0303]);
    chk("kept irq", 16'h0001, 16'(irq_seen));
    fl <= 7'h02;
    frame(2, 1'b1, 16'hA53C, 2'h1);
    chk("drop irq", 16'h0000, 16'(irq_seen));
    $display("check sequence done");
  endtask

  task automatic t_ports;
    dw[0] = 16'hC0DE;
    dw[1] = 16'h0F0F;
    role <= 5'h1F;
    fl <= 7'h00;
    frame(2, 1'b0, 16'h0000, 2'h0);
    chk("sink a", 16'h0F0F, tm.mem[16'h0211]);
    chk("sink b", 16'h0F0F, tm.mem[16'h0411]);
    chk("one src", 16'h0001, 16'(conf_seen));
    role <= 5'h01;
    fl <= 7'h30;
    xfer_start <= 1'b1;
    @(posedge mclk);
    xfer_start <= 1'b0;
    @(negedge mclk);
    chk("loop off", 16'h0000, 16'(busy));
    chk("src on", 16'h0001, 16'(loop_source_active));
    @(posedge mclk);
    fl <= 7'h50;
    dw[0] = 16'h7E57;
    frame(1, 1'b0, 16'h0000, 2'h0);
    chk("loop data", 16'h7E57, tm.mem[xfer_pkg::MSG_BASE + xfer_pkg::PAGE_OFS]);
    chk("src off", 16'h0000, 16'(loop_source_active));
    $display("ports done");
  endtask

  // mask forces the high byte only, so the forced word already matches the stored one
  task automatic t_force;
    tm.mem[16'h0500] = 16'hFF00;
    tm.mem[16'h0510] = 16'hAB00;
    tm.mem[16'h0501] = 16'h0000;
    tm.mem[16'h0200] = 16'hAB34;
    tm.mem[16'h0201] = 16'hBEEF;
    dw[0] = 16'h1234;
    dw[1] = 16'hBEEF;
    role <= 5'h01;
    sel <= 3'h7;
    fl <= 7'h03;
    frame(2, 1'b1, 16'h7777, 2'h0);
    chk("force acc", 16'h000C, 16'(n_acc));
    chk("forced word", 16'hAB34, tm.mem[16'h0210]);
    chk("force irq", 16'h0000, 16'(irq_seen));
    $display("force done");
  endtask

  initial
  begin
    foreach (tm.mem[a])
      tm.mem[a] = 16'h0000;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_strobe;
    t_index;
    t_compare;
    t_check_seq;
    t_ports;
    t_force;
    close_out;
  end
endmodule
`default_nettype wire
